// [rtl/sbru_pkg.sv]
// Shared constants for the single-bit rotate unit: opcodes, addressing
// modes, register offsets, flag positions and reset values.
// Assumes nothing of its surroundings; compiled before every other file.
`default_nettype none

package sbru_pkg;

  // Upper opcode byte of each instruction form.
  localparam logic [7:0] OPC_FILE_LEFT  = 8'hd6;
  localparam logic [7:0] OPC_FILE_RIGHT = 8'hd7;
  localparam logic [7:0] OPC_REG_LEFT   = 8'hd2;
  localparam logic [7:0] OPC_REG_RIGHT  = 8'hd3;

  // Working-register addressing modes.
  localparam logic [2:0] MODE_DIRECT  = 3'h0;
  localparam logic [2:0] MODE_IND     = 3'h1;
  localparam logic [2:0] MODE_POSTINC = 3'h2;
  localparam logic [2:0] MODE_POSTDEC = 3'h3;
  localparam logic [2:0] MODE_PREINC  = 3'h4;
  localparam logic [2:0] MODE_PREDEC  = 3'h5;

  typedef enum logic [1:0] {
    ROT_LEFT_NC  = 2'h0,
    ROT_RIGHT_C  = 2'h1,
    ROT_RIGHT_NC = 2'h2
  } sbru_rot_type;

  // Register offsets (byte addresses, low eight address bits decoded).
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STAT      = 8'h04;
  localparam logic [7:0] ADDR_FLAGS     = 8'h08;
  localparam logic [1:0] ADDR_DEFAULT_WORKING_REGISTER_WIN  = 2'h1;

  // Field positions.
  localparam int CTRL_EN_BIT      = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int FLAG_C_BIT       = 0;
  localparam int FLAG_Z_BIT       = 1;
  localparam int FLAG_N_BIT       = 3;

  // Reset values.
  localparam logic        CTRL_EN_RESET = 1'h1;
  localparam logic [15:0] DEFAULT_WORKING_REGISTER_RESET    = 16'h0000;
  localparam logic [3:0]  DEFAULT_DEFAULT_WORKING_REGISTER  = 4'h0;

  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

endpackage

`default_nettype wire

// [rtl/sbru_rotator.sv]
// Combinational one-bit rotator with negative, zero and carry results.
// Assumes the caller holds the operand and carry stable for the cycle.
`default_nettype none

module sbru_rotator (
  // Operation select
  input  wire sbru_pkg::sbru_rot_type rotOp,
  input  wire logic                   byteMode,
  // Operand and result
  input  wire logic [15:0]            operand,
  input  wire logic                   carryIn,
  output logic      [15:0]            result,
  output logic                        carryOut,
  output logic                        negative,
  output logic                        zero
);

  always_comb begin
    result   = operand;
    carryOut = carryIn;
    case (rotOp)
      sbru_pkg::ROT_LEFT_NC: begin
        // Old top bit wraps to bit zero; carry untouched.
        result = byteMode ? {8'h00, operand[6:0], operand[7]}
                          : {operand[14:0], operand[15]};
      end
      sbru_pkg::ROT_RIGHT_C: begin
        // Old carry enters the top bit, bit zero leaves to carry.
        result   = byteMode ? {8'h00, carryIn, operand[7:1]}
                            : {carryIn, operand[15:1]};
        carryOut = operand[0];
      end
      sbru_pkg::ROT_RIGHT_NC: begin
        result = byteMode ? {8'h00, operand[0], operand[7:1]}
                          : {operand[0], operand[15:1]};
      end
      default: begin
        result = operand;
      end
    endcase
    negative = byteMode ? result[7] : result[15];
    zero     = byteMode ? (result[7:0] == 8'h00) : (result == 16'h0000);
  end

endmodule

`default_nettype wire

// [rtl/sbru_core.sv]
// Single-bit rotate unit: decodes and executes the rotate instructions,
// holds the sixteen working registers and the status flags, and reaches
// data memory through a synchronous read/write port.
// Assumes a synchronous RAM that returns read data the cycle after its
// read strobe, and an AHB-Lite master with single word transfers.
`default_nettype none

module sbru_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Instruction issue
  input  wire logic        instrValid,
  input  wire logic [23:0] instrWord,
  output logic             instrReady,
  output logic             instrDone,
  output logic             instrIllegal,
  // Data memory port
  output logic      [15:0] dmAddr,
  output logic             dmRe,
  output logic             dmWe,
  output logic      [1:0]  dmByteEn,
  output logic      [15:0] dmWdata,
  input  wire logic [15:0] dmRdata
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_EXEC  = 4'b1000
  } sbru_state_type;

  // Effective address seen by a pointer mode.
  function automatic logic [15:0] eaOf(input logic [2:0] mode,
                                       input logic [15:0] ptr,
                                       input logic [15:0] step);
    case (mode)
      sbru_pkg::MODE_PREINC: eaOf = ptr + step;
      sbru_pkg::MODE_PREDEC: eaOf = ptr - step;
      default:               eaOf = ptr;
    endcase
  endfunction

  // Pointer value left behind by a pointer mode.
  function automatic logic [15:0] nextPtr(input logic [2:0] mode,
                                          input logic [15:0] ptr,
                                          input logic [15:0] step);
    case (mode)
      sbru_pkg::MODE_POSTINC, sbru_pkg::MODE_PREINC: nextPtr = ptr + step;
      sbru_pkg::MODE_POSTDEC, sbru_pkg::MODE_PREDEC: nextPtr = ptr - step;
      default:                                       nextPtr = ptr;
    endcase
  endfunction

  // Places a byte result into the low byte, keeping the upper one.
  function automatic logic [15:0] mergeLow(input logic [15:0] old,
                                           input logic [15:0] res,
                                           input logic byteOp);
    mergeLow = byteOp ? {old[15:8], res[7:0]} : res;
  endfunction

  logic        rstMeta_r;
  logic        rstSync_r;
  sbru_state_type state_r;
  logic [23:0] ir_r;
  logic [15:0] default_working_register_r [16];
  logic        flagN_r;
  logic        flagZ_r;
  logic        flagC_r;
  logic        ctrlEn_r;
  logic        illegal_r;
  logic [15:0] opnd_r;
  logic        srcMem_r;
  logic [15:0] memAddr_r;
  logic        memRe_r;
  logic        memWe_r;
  logic [1:0]  memBe_r;
  logic [15:0] memWdata_r;
  logic        done_r;
  logic        aValid_r;
  logic        aWrite_r;
  logic [7:0]  aAddr_r;
  logic [31:0] hrdata_r;

  // The asynchronous reset is released through two flops.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Instruction field decode.
  wire [7:0]  opHi       = ir_r[23:16];
  wire        sel15      = ir_r[15];
  wire        isFileLeft = (opHi == sbru_pkg::OPC_FILE_LEFT) && !sel15;
  wire        isFileRrc  = (opHi == sbru_pkg::OPC_FILE_RIGHT) && sel15;
  wire        isFileRrnc = (opHi == sbru_pkg::OPC_FILE_RIGHT) && !sel15;
  wire        isRegLeft  = (opHi == sbru_pkg::OPC_REG_LEFT) && !sel15;
  wire        isRegRrc   = (opHi == sbru_pkg::OPC_REG_RIGHT) && sel15;
  wire        isFile     = isFileLeft || isFileRrc || isFileRrnc;
  wire        isReg      = isRegLeft || isRegRrc;
  wire        byteMode   = ir_r[14];
  wire        destFile   = ir_r[13];
  wire [12:0] fileAddr   = ir_r[12:0];
  wire [2:0]  dMode      = ir_r[13:11];
  wire [3:0]  dIdx       = ir_r[10:7];
  wire [2:0]  sMode      = ir_r[6:4];
  wire [3:0]  sIdx       = ir_r[3:0];
  wire        modesOk    = (dMode <= sbru_pkg::MODE_PREDEC) &&
                           (sMode <= sbru_pkg::MODE_PREDEC);
  wire        legal      = isFile || (isReg && modesOk);
  wire        throughC   = isFileRrc || isRegRrc;
  wire [15:0] step       = byteMode ? sbru_pkg::STEP_BYTE
                                    : sbru_pkg::STEP_WORD;
  wire [15:0] srcW       = default_working_register_r[sIdx];
  wire [15:0] dstW       = default_working_register_r[dIdx];
  wire [15:0] dstEa      = eaOf(dMode, dstW, step);
  wire        inFetch    = (state_r == ST_FETCH);
  wire        inExec     = (state_r == ST_EXEC);
  wire        accept     = (state_r == ST_IDLE) && ctrlEn_r && instrValid;

  sbru_pkg::sbru_rot_type rotOp;
  assign rotOp = throughC ? sbru_pkg::ROT_RIGHT_C :
                 isFileRrnc ? sbru_pkg::ROT_RIGHT_NC
                            : sbru_pkg::ROT_LEFT_NC;

  // An odd memory address picks the upper byte of the word.
  wire [15:0] memWord  = memAddr_r[0] ? {8'h00, dmRdata[15:8]} : dmRdata;
  wire [15:0] operand  = srcMem_r ? memWord : opnd_r;

  logic [15:0] rotRes;
  logic        rotCarry;
  logic        rotNeg;
  logic        rotZero;

  sbru_rotator u_rotator (
    .rotOp    (rotOp),
    .byteMode (byteMode),
    .operand  (operand),
    .carryIn  (flagC_r),
    .result   (rotRes),
    .carryOut (rotCarry),
    .negative (rotNeg),
    .zero     (rotZero)
  );

  // Destination routing of the result in the execute cycle.
  wire execFileToMem = inExec && isFile && destFile;
  wire execFileToW0  = inExec && isFile && !destFile;
  wire execRegDirect = inExec && isReg && (dMode == sbru_pkg::MODE_DIRECT);
  wire execRegMem    = inExec && isReg && (dMode != sbru_pkg::MODE_DIRECT);
  wire fetchSrcPtr   = inFetch && legal && isReg &&
                       (sMode != sbru_pkg::MODE_DIRECT);
  wire [15:0] wrAddr = execFileToMem ? memAddr_r : dstEa;

  // Hardware write port of the working registers.
  logic        hwWe;
  logic [3:0]  hwIdx;
  logic [15:0] hwData;
  always_comb begin
    hwWe   = 1'b0;
    hwIdx  = sbru_pkg::DEFAULT_DEFAULT_WORKING_REGISTER;
    hwData = sbru_pkg::DEFAULT_WORKING_REGISTER_RESET;
    if (fetchSrcPtr) begin
      hwWe   = 1'b1;
      hwIdx  = sIdx;
      hwData = nextPtr(sMode, srcW, step);
    end else if (execFileToW0) begin
      hwWe   = 1'b1;
      hwIdx  = sbru_pkg::DEFAULT_DEFAULT_WORKING_REGISTER;
      hwData = mergeLow(default_working_register_r[sbru_pkg::DEFAULT_DEFAULT_WORKING_REGISTER], rotRes, byteMode);
    end else if (execRegDirect) begin
      hwWe   = 1'b1;
      hwIdx  = dIdx;
      hwData = mergeLow(dstW, rotRes, byteMode);
    end else if (execRegMem) begin
      hwWe   = 1'b1;
      hwIdx  = dIdx;
      hwData = nextPtr(dMode, dstW, step);
    end
  end

  // Each accepted word is one whole instruction, run through a short
  // fixed sequence; nothing overlaps so no operand hazards arise.
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r <= ST_IDLE;
      ir_r    <= 24'h000000;
      opnd_r  <= 16'h0000;
      srcMem_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            ir_r    <= instrWord;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          opnd_r   <= byteMode ? {8'h00, srcW[7:0]} : srcW;
          srcMem_r <= isFile || (sMode != sbru_pkg::MODE_DIRECT);
          if (!legal) begin
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
          end else if (isReg && (sMode == sbru_pkg::MODE_DIRECT)) begin
            state_r <= ST_EXEC;
          end else begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          done_r  <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Memory port: read strobe in the wait cycle, write strobe after exec.
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      memAddr_r  <= 16'h0000;
      memRe_r    <= 1'b0;
      memWe_r    <= 1'b0;
      memBe_r    <= 2'h0;
      memWdata_r <= 16'h0000;
    end else begin
      memRe_r <= 1'b0;
      memWe_r <= 1'b0;
      if (inFetch && legal && isFile) begin
        memAddr_r <= {3'h0, fileAddr};
        memRe_r   <= 1'b1;
      end else if (fetchSrcPtr) begin
        memAddr_r <= eaOf(sMode, srcW, step);
        memRe_r   <= 1'b1;
      end else if (execFileToMem || execRegMem) begin
        memAddr_r  <= wrAddr;
        memWe_r    <= 1'b1;
        memWdata_r <= byteMode ? {rotRes[7:0], rotRes[7:0]} : rotRes;
        memBe_r    <= !byteMode ? 2'h3 : (wrAddr[0] ? 2'h2 : 2'h1);
      end
    end
  end

  // AHB-Lite address phase capture and register decode.
  wire        aTake    = hsel && htrans[1] && hready;
  wire        swWrite  = aValid_r && aWrite_r;
  wire        swWinWr  = swWrite && (aAddr_r[7:6] == sbru_pkg::ADDR_DEFAULT_WORKING_REGISTER_WIN);
  wire        swCtrlWr = swWrite && (aAddr_r == sbru_pkg::ADDR_CTRL);
  wire        swStatWr = swWrite && (aAddr_r == sbru_pkg::ADDR_STAT);
  wire        swFlagWr = swWrite && (aAddr_r == sbru_pkg::ADDR_FLAGS);
  wire        illegalSet = inFetch && !legal;
  wire        illegalClr = swStatWr && hwdata[sbru_pkg::STAT_ILLEGAL_BIT];
  wire [7:0]  rdAddr   = haddr[7:0];

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    if (rdAddr[7:6] == sbru_pkg::ADDR_DEFAULT_WORKING_REGISTER_WIN) begin
      rdMux[15:0] = default_working_register_r[rdAddr[5:2]];
    end else if (rdAddr == sbru_pkg::ADDR_CTRL) begin
      rdMux[sbru_pkg::CTRL_EN_BIT] = ctrlEn_r;
    end else if (rdAddr == sbru_pkg::ADDR_STAT) begin
      rdMux[sbru_pkg::STAT_BUSY_BIT]    = (state_r != ST_IDLE);
      rdMux[sbru_pkg::STAT_ILLEGAL_BIT] = illegal_r;
    end else if (rdAddr == sbru_pkg::ADDR_FLAGS) begin
      rdMux[sbru_pkg::FLAG_C_BIT] = flagC_r;
      rdMux[sbru_pkg::FLAG_Z_BIT] = flagZ_r;
      rdMux[sbru_pkg::FLAG_N_BIT] = flagN_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      aValid_r <= 1'b0;
      aWrite_r <= 1'b0;
      aAddr_r  <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      if (hready) begin
        aValid_r <= aTake;
        aWrite_r <= hwrite;
        aAddr_r  <= rdAddr;
      end
      if (aTake && !hwrite) begin
        hrdata_r <= rdMux;
      end
    end
  end

  // Control, sticky error and flags; hardware wins over software.
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      ctrlEn_r  <= sbru_pkg::CTRL_EN_RESET;
      illegal_r <= 1'b0;
      flagN_r   <= 1'b0;
      flagZ_r   <= 1'b0;
      flagC_r   <= 1'b0;
    end else begin
      if (swCtrlWr) begin
        ctrlEn_r <= hwdata[sbru_pkg::CTRL_EN_BIT];
      end
      if (illegalSet) begin
        illegal_r <= 1'b1;
      end else if (illegalClr) begin
        illegal_r <= 1'b0;
      end
      if (inExec) begin
        flagN_r <= rotNeg;
        flagZ_r <= rotZero;
        if (throughC) begin
          flagC_r <= rotCarry;
        end
      end else if (swFlagWr) begin
        flagN_r <= hwdata[sbru_pkg::FLAG_N_BIT];
        flagZ_r <= hwdata[sbru_pkg::FLAG_Z_BIT];
        flagC_r <= hwdata[sbru_pkg::FLAG_C_BIT];
      end
    end
  end

  // Working registers: one generated flop set per register.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_default_working_register
      always_ff @(posedge clk_sys or negedge rstSync_r) begin
        if (!rstSync_r) begin
          default_working_register_r[gi] <= sbru_pkg::DEFAULT_WORKING_REGISTER_RESET;
        end else if (hwWe && (hwIdx == 4'(gi))) begin
          default_working_register_r[gi] <= hwData;
        end else if (swWinWr && (aAddr_r[5:2] == 4'(gi))) begin
          default_working_register_r[gi] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_r;
  assign instrReady   = (state_r == ST_IDLE) && ctrlEn_r;
  assign instrDone    = done_r;
  assign instrIllegal = illegal_r;
  assign dmAddr       = memAddr_r;
  assign dmRe         = memRe_r;
  assign dmWe         = memWe_r;
  assign dmByteEn     = memBe_r;
  assign dmWdata      = memWdata_r;

endmodule

`default_nettype wire

// [sim/sbru_checker.sv]
// Port-level properties of the single-bit rotate unit, bound to the core.
// Assumes the core's fixed sequence: read strobe, execute, then done.
`default_nettype none

module sbru_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Instruction port
  input wire logic        instrValid,
  input wire logic        instrReady,
  input wire logic        instrDone,
  // Data memory port
  input wire logic [15:0] dmAddr,
  input wire logic        dmRe,
  input wire logic        dmWe,
  input wire logic [1:0]  dmByteEn,
  input wire logic [15:0] dmWdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence takeSeq;
    instrValid && instrReady;
  endsequence

  sequence memReadSeq;
    dmRe ##1 !dmRe;
  endsequence

  chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait okay");
  chk_done_bound: assert property (takeSeq |-> ##[2:4] instrDone)
    else $error("instruction not done within four cycles");
  chk_done_pulse: assert property (instrDone |=> !instrDone)
    else $error("done lasted more than one cycle");
  chk_busy_refuse: assert property (takeSeq |=> !instrReady)
    else $error("ready while an instruction runs");
  chk_ready_on_done: assert property (instrDone |-> instrReady)
    else $error("not ready in the done cycle");
  chk_read_to_done: assert property (memReadSeq |-> ##1 instrDone)
    else $error("done not two cycles after the read strobe");
  chk_write_with_done: assert property (dmWe |-> instrDone)
    else $error("memory write outside the done cycle");
  chk_lane_match: assert property (dmWe |-> dmByteEn == 2'h3 ||
      dmByteEn == {dmAddr[0], !dmAddr[0]})
    else $error("byte lane does not follow the address");
  chk_byte_repl: assert property ((dmWe && dmByteEn != 2'h3) |->
      dmWdata[15:8] == dmWdata[7:0])
    else $error("byte write not replicated");
endmodule

bind sbru_core sbru_checker u_sbru_checker (
  .clk_sys    (clk_sys),
  .resetn     (resetn),
  .hreadyout  (hreadyout),
  .hresp      (hresp),
  .instrValid (instrValid),
  .instrReady (instrReady),
  .instrDone  (instrDone),
  .dmAddr     (dmAddr),
  .dmRe       (dmRe),
  .dmWe       (dmWe),
  .dmByteEn   (dmByteEn),
  .dmWdata    (dmWdata)
);

`default_nettype wire

// [sim/tb_single_bit_rotate_unit.sv]
// Self-checking bench of the rotate unit: bus tasks, instruction tasks.
// Assumes the core's hand-over timing; the bench plays the data RAM.
`default_nettype none

module tb_single_bit_rotate_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready;
  logic        hreadyout, hresp, instrReady, instrDone, instrIllegal;
  logic [31:0] hrdata;
  logic        instrValid = 1'b0;
  logic [23:0] instrWord = 24'h0;
  logic [15:0] dmAddr, dmWdata;
  logic        dmRe, dmWe;
  logic [1:0]  dmByteEn;
  logic [15:0] dmRdata = 16'h0;
  logic [15:0] mem [0:4095];
  int          n_fail = 0;
  int          num_checks = 0;
  logic [15:0] resW [3] = '{16'h42dc, 16'h90b7, 16'h10b7};
  logic [3:0]  resF [3] = '{4'h1, 4'h8, 4'h1};

  assign hready = hreadyout;

  sbru_core u_sbru_core (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .instrDone(instrDone),
    .instrIllegal(instrIllegal), .dmAddr(dmAddr), .dmRe(dmRe),
    .dmWe(dmWe), .dmByteEn(dmByteEn), .dmWdata(dmWdata),
    .dmRdata(dmRdata)
  );

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Read data is only valid the cycle after a strobe; otherwise it toggles.
  always @(posedge clk_sys) begin
    if (dmRe) dmRdata <= mem[dmAddr[12:1]];
    else dmRdata <= ~dmRdata;
    if (dmWe && dmByteEn[0]) mem[dmAddr[12:1]][7:0] <= dmWdata[7:0];
    if (dmWe && dmByteEn[1]) mem[dmAddr[12:1]][15:8] <= dmWdata[15:8];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask

  task automatic exec(input logic [23:0] w, input int lat);
    int n;
    instrWord <= w;
    instrValid <= 1'b1;
    @(posedge clk_sys);
    while (instrReady !== 1'b1) @(posedge clk_sys);
    instrValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (instrDone !== 1'b1 && n < 20);
    check(32'(n), 32'(lat));
  endtask

  function automatic logic [23:0] regWord(input logic [7:0] op,
      input int b15, input int bb, input int q,
      input int d, input int p, input int s);
    return {op, 1'(b15), 1'(bb), 3'(q), 4'(d), 3'(p), 4'(s)};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(sbru_pkg::ADDR_CTRL, 32'h1);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h0);
    rdchk(8'h0c, 32'h0);
    $display("test reset done");
    wr(8'h40, 32'h9976);
    wr(8'h4c, 32'h5879);
    wr(sbru_pkg::ADDR_FLAGS, 32'h1);
    exec(regWord(sbru_pkg::OPC_REG_LEFT, 0, 1, 0, 3, 0, 0), 3);
    rdchk(8'h4c, 32'h58ec);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h9);
    wr(8'h4c, 32'h5879);
    exec(regWord(sbru_pkg::OPC_REG_RIGHT, 1, 1, 0, 3, 0, 0), 3);
    rdchk(8'h4c, 32'h58bb);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h8);
    wr(8'h54, 32'h0);
    wr(8'h58, 32'hffff);
    exec(regWord(sbru_pkg::OPC_REG_LEFT, 0, 0, 0, 6, 0, 5), 3);
    rdchk(8'h58, 32'h0);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h2);
    $display("test register forms done");
    mem[12'h919] = 16'he807;
    exec({sbru_pkg::OPC_FILE_LEFT, 3'b011, 13'h1233}, 4);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h8);
    check(32'(mem[12'h919]), 32'hd107);
    mem[12'hfff] = 16'h0100;
    wr(sbru_pkg::ADDR_FLAGS, 32'h1);
    exec({sbru_pkg::OPC_FILE_RIGHT, 3'b111, 13'h1fff}, 4);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h9);
    check(32'(mem[12'hfff]), 32'h8000);
    for (int i = 0; i < 3; i++) begin
      mem[12'h410] = 16'h216e;
      wr(8'h40, 32'h5601);
      wr(sbru_pkg::ADDR_FLAGS, 32'h1);
      exec({(i == 0) ? sbru_pkg::OPC_FILE_LEFT : sbru_pkg::OPC_FILE_RIGHT,
            i == 1, 2'b00, 13'h0820}, 4);
      rdchk(8'h40, {16'h0, resW[i]});
      rdchk(sbru_pkg::ADDR_FLAGS, {28'h0, resF[i]});
      check(32'(mem[12'h410]), 32'h216e);
    end
    $display("test file forms done");
    wr(8'h48, 32'h0100);
    wr(8'h60, 32'h0200);
    mem[12'h080] = 16'h8001;
    exec(regWord(sbru_pkg::OPC_REG_LEFT, 0, 0, 1, 8, 2, 2), 4);
    rdchk(8'h48, 32'h0102);
    check(32'(mem[12'h100]), 32'h0003);
    wr(sbru_pkg::ADDR_FLAGS, 32'h0);
    mem[12'h081] = 16'h0300;
    mem[12'h0ff] = 16'h00aa;
    exec(regWord(sbru_pkg::OPC_REG_RIGHT, 1, 1, 5, 8, 4, 2), 4);
    rdchk(8'h48, 32'h0103);
    rdchk(8'h60, 32'h01ff);
    rdchk(sbru_pkg::ADDR_FLAGS, 32'h1);
    check(32'(mem[12'h0ff]), 32'h01aa);
    exec(regWord(sbru_pkg::OPC_REG_LEFT, 0, 1, 3, 8, 0, 0), 3);
    rdchk(8'h60, 32'h01fe);
    check(32'(mem[12'h0ff]), 32'h6faa);
    $display("test indirect done");
    exec(regWord(sbru_pkg::OPC_REG_LEFT, 0, 0, 6, 1, 0, 1), 2);
    check({31'h0, instrIllegal}, 32'h1);
    wr(sbru_pkg::ADDR_STAT, 32'h2);
    exec(24'hffffff, 2);
    rdchk(sbru_pkg::ADDR_STAT, 32'h2);
    check({31'h0, instrIllegal}, 32'h1);
    wr(sbru_pkg::ADDR_STAT, 32'h2);
    rdchk(sbru_pkg::ADDR_STAT, 32'h0);
    wr(sbru_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    check({31'h0, instrReady}, 32'h0);
    wr(sbru_pkg::ADDR_CTRL, 32'h1);
    $display("test illegal and disable done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
